// *** ssvs_regs.svh ***
// Register offsets, field positions, factory defaults and sizes of the sleep
// state and voltage select bank.
// Assumes it is included by the package and by the bank module by bare name.
`ifndef SSVS_REGS_SVH
`define SSVS_REGS_SVH

`define SSVS_OFS_KEEP_ACTIVE_ONE 8'h27
`define SSVS_OFS_KEEP_ACTIVE_TWO 8'h28
`define SSVS_OFS_SWITCH_OFF_ONE 8'h29
`define SSVS_OFS_SWITCH_OFF_TWO 8'h2a
`define SSVS_OFS_BANK_SELECT 8'h2b
`define SSVS_OFS_PIN_MAP 8'h2c

`define SSVS_RST_KEEP_ACTIVE_ONE 8'h00
`define SSVS_RST_KEEP_ACTIVE_TWO 8'h00
`define SSVS_RST_SWITCH_OFF_ONE 8'h00
`define SSVS_RST_SWITCH_OFF_TWO 8'h00
`define SSVS_RST_BANK_SELECT 8'h00
`define SSVS_RST_PIN_MAP 8'he4

`define SSVS_KEEP_TWO_USED_MASK 8'h3f
`define SSVS_THERMAL_OFF_BIT 7
`define SSVS_SLOW_CLOCK_OFF_BIT 6
`define SSVS_BANK_LINEAR_LSB 4
`define SSVS_MAP_FIELD_WIDTH 2
`define SSVS_RAIL_COUNT 14
`define SSVS_LINEAR_COUNT 10
`define SSVS_BUCK_COUNT 4
`define SSVS_MAPPED_COUNT 4
`define SSVS_PIN_SYNC_WIDTH 6

`endif

// *** ssvs_pkg.sv ***
// Types shared by the sleep state and voltage select bank and its bench.
// Assumes ssvs_regs.svh is on the include path.
`include "ssvs_regs.svh"

package ssvs_pkg;

    typedef enum logic [1:0] {
        SSVS_RAIL_ACTIVE = 2'h0,
        SSVS_RAIL_ECONOMY = 2'h1,
        SSVS_RAIL_OFF = 2'h2
    } ssvs_rail_mode_e;

    typedef enum logic [1:0] {
        SSVS_PWR_RUN = 2'h1,
        SSVS_PWR_SLEEP = 2'h2
    } ssvs_pwr_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ssvs_reg_req_s;

    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
    } ssvs_reg_rsp_s;

    typedef ssvs_rail_mode_e [`SSVS_RAIL_COUNT-1:0] ssvs_rail_modes_t;

endpackage : ssvs_pkg

// *** ssvs_sync.sv ***
// Two flip-flop synchroniser for pins that arrive from outside the clock domain.
// Assumes a free-running clk and a synchronous active-low reset.
module ssvs_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;

endmodule : ssvs_sync

// *** ssvs_sleep_bank.sv ***
// Sleep state and voltage select register bank with the sleep decision logic.
// Assumes a 100 MHz clk, a synchronous active-low reset taken as power-on reset,
// a register port from the control interface on the same clock, and sleep and
// scaling pins plus the strap arriving asynchronously from the board.
`include "ssvs_regs.svh"

// What this block does
// - Thermal-monitor and slow-clock-output sleep bits keep their function on in SLEEP at 0 and switch it off at 1.
// - A rail's switch-off bit at 0 leaves SLEEP behaviour to keep-active, at 1 turns it off when keep-active is 0.
// - In SLEEP a rail is economy for keep 0 and off 0 (active for a buck with forced-mode 1), active for keep 1, and off for keep 0 with off 1.
// - Each bank-select bit picks the primary voltage register at 0 and the alternate at 1, in every outcome.
// - Each linear pin-map field picks scaling pin 1, 2, 3 or 4 for codes 00, 01, 10 and 11.
// - A mapped linear regulator's bank-select bit is set and cleared to follow the selected pin.
// - The fourth linear regulator's pin map only acts while the second configuration strap is low.
// - Map fields sit at bits 7-6, 5-4, 3-2 and 1-0 for linear regulators 4, 3, 2 and 1.
// - Power-on reset reloads the bank-select and pin-map registers with factory values.
// - Keep-active 0 with switch-off 0 gives economy unless the buck's forced-mode bit is 1, and keep-active 1 keeps it active.
module ssvs_sleep_bank #(
    parameter logic [7:0] KEEP_ACTIVE_ONE_FACTORY = `SSVS_RST_KEEP_ACTIVE_ONE,
    parameter logic [7:0] KEEP_ACTIVE_TWO_FACTORY = `SSVS_RST_KEEP_ACTIVE_TWO,
    parameter logic [7:0] SWITCH_OFF_ONE_FACTORY = `SSVS_RST_SWITCH_OFF_ONE,
    parameter logic [7:0] SWITCH_OFF_TWO_FACTORY = `SSVS_RST_SWITCH_OFF_TWO,
    parameter logic [7:0] BANK_SELECT_FACTORY = `SSVS_RST_BANK_SELECT,
    parameter logic [7:0] PIN_MAP_FACTORY = `SSVS_RST_PIN_MAP
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire ssvs_pkg::ssvs_reg_req_s reg_req,
    output ssvs_pkg::ssvs_reg_rsp_s reg_rsp,
    input wire logic sleep_pin,
    input wire logic [3:0] buck_scaling_pin,
    input wire logic config_strap_two,
    input wire logic [3:0] buck_forced_mode,
    output ssvs_pkg::ssvs_rail_modes_t rail_mode,
    output logic [7:0] voltage_bank_select,
    output logic thermal_monitor_en,
    output logic slow_clock_out_en,
    output logic in_sleep
);
    import ssvs_pkg::*;

    // Picks one scaling pin level by a two-bit map code.
    function automatic logic pin_by_code(input logic [1:0] code, input logic [3:0] pins);
        logic lvl;
        lvl = 1'b0;
        unique case (code)
            2'h0: lvl = pins[0];
            2'h1: lvl = pins[1];
            2'h2: lvl = pins[2];
            2'h3: lvl = pins[3];
        endcase
        return lvl;
    endfunction : pin_by_code

    // Sleep outcome of one rail from its keep-active, switch-off and forced-mode bits.
    function automatic ssvs_rail_mode_e sleep_outcome(input logic keep, input logic off,
                                                      input logic forced);
        ssvs_rail_mode_e m;
        m = SSVS_RAIL_ACTIVE;
        if (keep) begin
            m = SSVS_RAIL_ACTIVE;
        end else if (off) begin
            m = SSVS_RAIL_OFF;
        end else if (forced) begin
            m = SSVS_RAIL_ACTIVE;
        end else begin
            m = SSVS_RAIL_ECONOMY;
        end
        return m;
    endfunction : sleep_outcome

    // Register address decode shared by the write and read paths.
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction : addr_hit

    // Pin synchronisation: sleep, four scaling pins and the strap.
    logic [`SSVS_PIN_SYNC_WIDTH-1:0] pins_sync;
    logic sleep_s;
    logic [3:0] scaling_s;
    logic strap_s;

    ssvs_sync #(
        .W(`SSVS_PIN_SYNC_WIDTH)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({config_strap_two, buck_scaling_pin, sleep_pin}),
        .sync_out(pins_sync)
    );

    assign sleep_s = pins_sync[0];
    assign scaling_s = pins_sync[4:1];
    assign strap_s = pins_sync[5];

    // Register group.
    logic [7:0] keep_active_one_reg;
    logic [7:0] keep_active_one_next;
    logic [7:0] keep_active_two_reg;
    logic [7:0] keep_active_two_next;
    logic [7:0] sleep_switch_off_one_reg;
    logic [7:0] sleep_switch_off_one_next;
    logic [7:0] sleep_switch_off_two_reg;
    logic [7:0] sleep_switch_off_two_next;
    logic [7:0] voltage_bank_select_reg;
    logic [7:0] voltage_bank_select_next;
    logic [7:0] scaling_pin_map_reg;
    logic [7:0] scaling_pin_map_next;
    ssvs_reg_rsp_s rsp_reg;
    ssvs_reg_rsp_s rsp_next;

    // Per linear regulator 1 to 4: whether the pin drives its bank bit, and the level.
    logic [`SSVS_MAPPED_COUNT-1:0] map_active;
    logic [`SSVS_MAPPED_COUNT-1:0] map_level;

    genvar gi;
    generate
        for (gi = 0; gi < `SSVS_MAPPED_COUNT; gi++) begin : g_map
            // Field of regulator gi+1 sits at bits 2*gi+1 : 2*gi.
            assign map_level[gi] = pin_by_code(
                scaling_pin_map_reg[gi*`SSVS_MAP_FIELD_WIDTH +: `SSVS_MAP_FIELD_WIDTH],
                scaling_s);
            if (gi == `SSVS_MAPPED_COUNT - 1) begin : g_strap
                assign map_active[gi] = ~strap_s;
            end else begin : g_plain
                assign map_active[gi] = 1'b1;
            end
        end
    endgenerate

    always_comb begin
        keep_active_one_next = keep_active_one_reg;
        keep_active_two_next = keep_active_two_reg;
        sleep_switch_off_one_next = sleep_switch_off_one_reg;
        sleep_switch_off_two_next = sleep_switch_off_two_reg;
        voltage_bank_select_next = voltage_bank_select_reg;
        scaling_pin_map_next = scaling_pin_map_reg;
        rsp_next.ack = reg_req.wr | reg_req.rd;
        rsp_next.rdata = 8'h00;

        if (reg_req.wr) begin
            if (addr_hit(reg_req.addr, `SSVS_OFS_KEEP_ACTIVE_ONE)) begin
                keep_active_one_next = reg_req.wdata;
            end
            if (addr_hit(reg_req.addr, `SSVS_OFS_KEEP_ACTIVE_TWO)) begin
                keep_active_two_next = reg_req.wdata & `SSVS_KEEP_TWO_USED_MASK;
            end
            if (addr_hit(reg_req.addr, `SSVS_OFS_SWITCH_OFF_ONE)) begin
                sleep_switch_off_one_next = reg_req.wdata;
            end
            if (addr_hit(reg_req.addr, `SSVS_OFS_SWITCH_OFF_TWO)) begin
                sleep_switch_off_two_next = reg_req.wdata;
            end
            if (addr_hit(reg_req.addr, `SSVS_OFS_BANK_SELECT)) begin
                voltage_bank_select_next = reg_req.wdata;
            end
            if (addr_hit(reg_req.addr, `SSVS_OFS_PIN_MAP)) begin
                scaling_pin_map_next = reg_req.wdata;
            end
        end

        // A mapped bank bit follows its pin, over a software write in the same cycle.
        for (int i = 0; i < `SSVS_MAPPED_COUNT; i++) begin
            if (map_active[i]) begin
                voltage_bank_select_next[`SSVS_BANK_LINEAR_LSB + i] = map_level[i];
            end
        end

        // A read returns the value held before any write in the same cycle.
        if (reg_req.rd) begin
            if (addr_hit(reg_req.addr, `SSVS_OFS_KEEP_ACTIVE_ONE)) begin
                rsp_next.rdata = keep_active_one_reg;
            end else if (addr_hit(reg_req.addr, `SSVS_OFS_KEEP_ACTIVE_TWO)) begin
                rsp_next.rdata = keep_active_two_reg & `SSVS_KEEP_TWO_USED_MASK;
            end else if (addr_hit(reg_req.addr, `SSVS_OFS_SWITCH_OFF_ONE)) begin
                rsp_next.rdata = sleep_switch_off_one_reg;
            end else if (addr_hit(reg_req.addr, `SSVS_OFS_SWITCH_OFF_TWO)) begin
                rsp_next.rdata = sleep_switch_off_two_reg;
            end else if (addr_hit(reg_req.addr, `SSVS_OFS_BANK_SELECT)) begin
                rsp_next.rdata = voltage_bank_select_reg;
            end else if (addr_hit(reg_req.addr, `SSVS_OFS_PIN_MAP)) begin
                rsp_next.rdata = scaling_pin_map_reg;
            end else begin
                rsp_next.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            keep_active_one_reg <= KEEP_ACTIVE_ONE_FACTORY;
            keep_active_two_reg <= KEEP_ACTIVE_TWO_FACTORY & `SSVS_KEEP_TWO_USED_MASK;
            sleep_switch_off_one_reg <= SWITCH_OFF_ONE_FACTORY;
            sleep_switch_off_two_reg <= SWITCH_OFF_TWO_FACTORY;
            voltage_bank_select_reg <= BANK_SELECT_FACTORY;
            scaling_pin_map_reg <= PIN_MAP_FACTORY;
            rsp_reg <= '0;
        end else begin
            keep_active_one_reg <= keep_active_one_next;
            keep_active_two_reg <= keep_active_two_next;
            sleep_switch_off_one_reg <= sleep_switch_off_one_next;
            sleep_switch_off_two_reg <= sleep_switch_off_two_next;
            voltage_bank_select_reg <= voltage_bank_select_next;
            scaling_pin_map_reg <= scaling_pin_map_next;
            rsp_reg <= rsp_next;
        end
    end

    // Power state group.
    ssvs_pwr_state_e state_reg;
    ssvs_pwr_state_e state_next;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SSVS_PWR_RUN: begin
                if (sleep_s) begin
                    state_next = SSVS_PWR_SLEEP;
                end
            end
            SSVS_PWR_SLEEP: begin
                if (!sleep_s) begin
                    state_next = SSVS_PWR_RUN;
                end
            end
            default: begin
                state_next = SSVS_PWR_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= SSVS_PWR_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Output group: rail outcomes use the current registers, thermal, slow-clock and bank outcomes the next values.
    logic [`SSVS_RAIL_COUNT-1:0] keep_vec;
    logic [`SSVS_RAIL_COUNT-1:0] off_vec;
    logic [`SSVS_RAIL_COUNT-1:0] forced_vec;
    ssvs_rail_modes_t rail_mode_reg;
    ssvs_rail_modes_t rail_mode_next;
    logic thermal_en_reg;
    logic thermal_en_next;
    logic slow_clock_en_reg;
    logic slow_clock_en_next;
    logic in_sleep_reg;
    logic in_sleep_next;
    logic [7:0] bank_out_reg;
    logic [7:0] bank_out_next;

    // Rails 0-9 are linear regulators 1-10, rails 10-13 are bucks 1-4.
    assign keep_vec = {keep_active_two_reg[5:0], keep_active_one_reg};
    assign off_vec = {sleep_switch_off_two_reg[5:0], sleep_switch_off_one_reg};
    assign forced_vec = {buck_forced_mode, {`SSVS_LINEAR_COUNT{1'b0}}};

    always_comb begin
        in_sleep_next = (state_next == SSVS_PWR_SLEEP);
        bank_out_next = voltage_bank_select_next;
        thermal_en_next = 1'b1;
        slow_clock_en_next = 1'b1;
        for (int r = 0; r < `SSVS_RAIL_COUNT; r++) begin
            rail_mode_next[r] = SSVS_RAIL_ACTIVE;
        end
        if (in_sleep_next) begin
            thermal_en_next = ~sleep_switch_off_two_next[`SSVS_THERMAL_OFF_BIT];
            slow_clock_en_next = ~sleep_switch_off_two_next[`SSVS_SLOW_CLOCK_OFF_BIT];
            for (int r = 0; r < `SSVS_RAIL_COUNT; r++) begin
                rail_mode_next[r] = sleep_outcome(keep_vec[r], off_vec[r],
                                                  forced_vec[r]);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_sleep_reg <= 1'b0;
            bank_out_reg <= BANK_SELECT_FACTORY;
            thermal_en_reg <= 1'b1;
            slow_clock_en_reg <= 1'b1;
            rail_mode_reg <= ssvs_rail_modes_t'({`SSVS_RAIL_COUNT{SSVS_RAIL_ACTIVE}});
        end else begin
            in_sleep_reg <= in_sleep_next;
            bank_out_reg <= bank_out_next;
            thermal_en_reg <= thermal_en_next;
            slow_clock_en_reg <= slow_clock_en_next;
            rail_mode_reg <= rail_mode_next;
        end
    end

    assign reg_rsp = rsp_reg;
    assign rail_mode = rail_mode_reg;
    assign voltage_bank_select = bank_out_reg;
    assign thermal_monitor_en = thermal_en_reg;
    assign slow_clock_out_en = slow_clock_en_reg;
    assign in_sleep = in_sleep_reg;

endmodule : ssvs_sleep_bank

// *** ssvs_chk_assertions.sv ***
// Concurrent checks on the ports of the sleep state and voltage select bank.
// Assumes one clock domain and a synchronous active-low reset; bound to the bank.
module ssvs_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire ssvs_pkg::ssvs_reg_req_s reg_req,
    input wire ssvs_pkg::ssvs_reg_rsp_s reg_rsp,
    input wire logic sleep_pin,
    input wire logic [3:0] buck_scaling_pin,
    input wire logic config_strap_two,
    input wire logic [3:0] buck_forced_mode,
    input wire ssvs_pkg::ssvs_rail_modes_t rail_mode,
    input wire logic [7:0] voltage_bank_select,
    input wire logic thermal_monitor_en,
    input wire logic slow_clock_out_en,
    input wire logic in_sleep
);
    import ssvs_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic bank_wr;
    assign bank_wr = reg_req.wr && reg_req.addr == 8'h2b;

    property p_sleep_enter;
        sleep_pin [*3] |=> in_sleep;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter) else $error("sleep entry late");
    property p_sleep_exit;
        !sleep_pin [*3] |=> !in_sleep;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit late");
    property p_run_active;
        !in_sleep |-> rail_mode == '0 && thermal_monitor_en && slow_clock_out_en;
    endproperty
    a_run_active: assert property (p_run_active) else $error("run state not active");
    property p_forced;
        in_sleep && $past(buck_forced_mode) == 4'hf |-> rail_mode[10] != SSVS_RAIL_ECONOMY
            && rail_mode[11] != SSVS_RAIL_ECONOMY && rail_mode[12] != SSVS_RAIL_ECONOMY
            && rail_mode[13] != SSVS_RAIL_ECONOMY;
    endproperty
    a_forced: assert property (p_forced) else $error("forced buck in economy");
    property p_pins_high;
        (buck_scaling_pin == 4'hf && !config_strap_two) [*3] |=> voltage_bank_select[7:4] == 4'hf;
    endproperty
    a_pins_high: assert property (p_pins_high) else $error("bank not following pins");
    property p_pins_low;
        (buck_scaling_pin == 4'h0 && !config_strap_two) [*3] |=> voltage_bank_select[7:4] == 4'h0;
    endproperty
    a_pins_low: assert property (p_pins_low) else $error("bank not following pins");
    property p_bank_soft;
        !bank_wr |=> $stable(voltage_bank_select[3:0]);
    endproperty
    a_bank_soft: assert property (p_bank_soft) else $error("buck bank bits moved");
    property p_strap_hold;
        config_strap_two [*2] ##1 (config_strap_two && !bank_wr) |=> $stable(voltage_bank_select[7]);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("unmapped bit moved");

    c_sleep: cover property ($rose(in_sleep));
    c_off: cover property (in_sleep && rail_mode[0] == SSVS_RAIL_OFF);
    c_read: cover property (reg_rsp.ack && reg_rsp.rdata != 8'h00);
endmodule : ssvs_chk

bind ssvs_sleep_bank ssvs_chk u_chk (
    .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rsp(reg_rsp), .sleep_pin(sleep_pin),
    .buck_scaling_pin(buck_scaling_pin), .config_strap_two(config_strap_two),
    .buck_forced_mode(buck_forced_mode), .rail_mode(rail_mode),
    .voltage_bank_select(voltage_bank_select), .thermal_monitor_en(thermal_monitor_en),
    .slow_clock_out_en(slow_clock_out_en), .in_sleep(in_sleep)
);

// *** ssvs_host.sv ***
// Host model: drives the register port and the board pins of the bank.
// Assumes every access is acknowledged one cycle after its request edge.
module ssvs_host (
    input wire logic clk,
    output ssvs_pkg::ssvs_reg_req_s reg_req,
    input wire ssvs_pkg::ssvs_reg_rsp_s reg_rsp,
    output logic sleep_pin,
    output logic [3:0] buck_scaling_pin,
    output logic config_strap_two,
    output logic [3:0] buck_forced_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    import ssvs_pkg::*;
    initial begin
        reg_req = '0;
        sleep_pin = 1'b0;
        buck_scaling_pin = 4'h0;
        config_strap_two = 1'b0;
        buck_forced_mode = 4'h0;
    end
    // Address and data are inverted after release so stale values never look valid.
    task automatic access(input logic write, input logic [7:0] addr, input logic [7:0] wdata,
                          output logic ack, output logic [7:0] rdata);
        @(negedge clk);
        reg_req.wr = write;
        reg_req.rd = !write;
        reg_req.addr = addr;
        reg_req.wdata = wdata;
        @(negedge clk);
        ack = reg_rsp.ack;
        rdata = reg_rsp.rdata;
        reg_req.wr = 1'b0;
        reg_req.rd = 1'b0;
        reg_req.addr = ~addr;
        reg_req.wdata = ~wdata;
    endtask : access
endmodule : ssvs_host

// *** tb.sv ***
// Self-checking bench for the sleep state and voltage select bank.
// Assumes the package, the bank, the host model and the checker are compiled first.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ssvs_pkg::*;
    typedef struct packed {
        logic [7:0] k1, k2, o1, o2;
        logic [3:0] f;
        logic therm, sclk;
    } ssvs_tb_row_s;
    logic clk, rst_n, sleep_pin, config_strap_two, thermal_monitor_en, slow_clock_out_en, in_sleep;
    logic [3:0] buck_scaling_pin, buck_forced_mode;
    logic [7:0] voltage_bank_select, rdat;
    logic ack;
    logic [13:0] keep, off, fz;
    ssvs_reg_req_s reg_req;
    ssvs_reg_rsp_s reg_rsp;
    ssvs_rail_modes_t rail_mode;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    ssvs_tb_row_s rows [6] = '{'{8'h00, 8'h00, 8'h00, 8'h00, 4'h0, 1'b1, 1'b1},
        '{8'hff, 8'h3f, 8'h00, 8'h00, 4'h0, 1'b1, 1'b1}, '{8'h00, 8'h00, 8'hff, 8'hff, 4'h0, 1'b0, 1'b0},
        '{8'h0f, 8'h05, 8'hf0, 8'hca, 4'h5, 1'b0, 1'b0}, '{8'h00, 8'h00, 8'h00, 8'h80, 4'hf, 1'b0, 1'b1},
        '{8'h00, 8'h00, 8'h00, 8'h40, 4'h0, 1'b1, 1'b0}};

    ssvs_host host (.clk(clk), .reg_req(reg_req), .reg_rsp(reg_rsp), .sleep_pin(sleep_pin),
        .buck_scaling_pin(buck_scaling_pin), .config_strap_two(config_strap_two),
        .buck_forced_mode(buck_forced_mode));
    ssvs_sleep_bank dut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rsp(reg_rsp),
        .sleep_pin(sleep_pin), .buck_scaling_pin(buck_scaling_pin),
        .config_strap_two(config_strap_two), .buck_forced_mode(buck_forced_mode),
        .rail_mode(rail_mode), .voltage_bank_select(voltage_bank_select),
        .thermal_monitor_en(thermal_monitor_en), .slow_clock_out_en(slow_clock_out_en),
        .in_sleep(in_sleep));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic complete_run();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d, ack, rdat);
        check("write ack", ack, 1'b1);
        check("write data", rdat, 8'h00);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.access(1'b0, a, 8'h00, ack, rdat);
        check("read ack", ack, 1'b1);
        check("read data", rdat, e);
    endtask : rd_chk

    task automatic settle();
        repeat (4) @(negedge clk);
    endtask : settle

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 6; i++) rd_chk(8'(8'h27 + i), (i == 5) ? 8'he4 : 8'h00);
    endtask : do_reset

    function automatic logic [1:0] exp_mode(input logic k, input logic o, input logic f);
        if (k) return 2'h0;
        if (o) return 2'h2;
        return f ? 2'h0 : 2'h1;
    endfunction : exp_mode

    initial begin
        do_reset();
        wr(8'h28, 8'hff);
        rd_chk(8'h28, 8'h3f);
        wr(8'h30, 8'hff);
        rd_chk(8'h30, 8'h00);
        wr(8'h2b, 8'h0a);
        rd_chk(8'h2b, 8'h0a);
        foreach (rows[n]) begin
            wr(8'h27, rows[n].k1);
            wr(8'h28, rows[n].k2);
            wr(8'h29, rows[n].o1);
            wr(8'h2a, rows[n].o2);
            host.buck_forced_mode = rows[n].f;
            keep = {rows[n].k2[5:0], rows[n].k1};
            off = {rows[n].o2[5:0], rows[n].o1};
            fz = {rows[n].f, 10'h000};
            host.sleep_pin = 1'b1;
            settle();
            check("in_sleep", in_sleep, 1'b1);
            check("thermal", thermal_monitor_en, rows[n].therm);
            check("slow clock", slow_clock_out_en, rows[n].sclk);
            for (int i = 0; i < 14; i++) begin
                check("rail", rail_mode[i], exp_mode(keep[i], off[i], fz[i]));
            end
            check("bank", voltage_bank_select, 8'h0a);
            host.sleep_pin = 1'b0;
            settle();
            check("run rails", {in_sleep, rail_mode, thermal_monitor_en, slow_clock_out_en},
                31'h3);
        end
        for (int c = 0; c < 4; c++) begin
            wr(8'h2c, {4{2'(c)}});
            host.buck_scaling_pin = 4'(1 << c);
            settle();
            check("bank", voltage_bank_select, 8'hfa);
            host.buck_scaling_pin = ~4'(1 << c);
            settle();
            check("bank", voltage_bank_select, 8'h0a);
        end
        host.buck_scaling_pin = 4'hf;
        settle();
        check("bank", voltage_bank_select, 8'hfa);
        wr(8'h2c, 8'h1b);
        host.buck_scaling_pin = 4'h1;
        settle();
        rd_chk(8'h2b, 8'h8a);
        host.buck_scaling_pin = 4'h0;
        host.config_strap_two = 1'b1;
        settle();
        wr(8'h2b, 8'h80);
        rd_chk(8'h2b, 8'h80);
        host.config_strap_two = 1'b0;
        settle();
        rd_chk(8'h2b, 8'h00);
        do_reset();
        complete_run();
    end
endmodule : tb
